// [hw/lsc_defines.svh]
// How it works
// R1: Reset starts Idle until advertising enabled.
// R2: Enable moves Idle to Advertising, clear returns.
// R3: Idle starts no radio, raises no events.
// R4: One event per interval on 37,38,39.
// R5: After each packet, listen for reply.
// R6: Scan request answered with scan response.
// R7: Connect request answered, enter slave connection.
// R8: Master terminate leaves the connection.
// R9: Local terminate sends terminate, then leaves.
// R10: Supervision timeout with no packet leaves connection.
// R11: On leaving, advertise if enable set, else Idle.
// R12: Advertising and connection are separate build options.
// R13: Flag duration expiry, scan response, connection events.
// R14: State code: Idle 0, Adv bit0, Conn bit3.
// R15: Enable changes take effect at event end.
//
// Purpose: Constants for the slave link state controller.
// Assumes: 125 MHz system clock.
// Notes: Times are in microseconds and converted to cycles.
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH
`define LSC_CLK_MHZ 125
`define LSC_ADV_INTERVAL_US 100000
`define LSC_ADV_INTERVAL_CYC (`LSC_ADV_INTERVAL_US * `LSC_CLK_MHZ)
`define LSC_LISTEN_US 200
`define LSC_LISTEN_CYC (`LSC_LISTEN_US * `LSC_CLK_MHZ)
`define LSC_SUPERVISION_US 1000000
`define LSC_SUPERVISION_CYC (`LSC_SUPERVISION_US * `LSC_CLK_MHZ)
`define LSC_ADV_DURATION_US 10000000
`define LSC_ADV_DURATION_CYC (`LSC_ADV_DURATION_US * `LSC_CLK_MHZ)
`define LSC_CODE_IDLE 4'h0
`define LSC_CODE_ADV 4'h1
`define LSC_CODE_CONN 4'h8
`define LSC_CH_FIRST 6'h25
`define LSC_CH_LAST 6'h27
`endif

// [hw/lsc_pkg.sv]
// Purpose: Types for the slave link state controller.
// Assumes: Nothing beyond the defines header.
// Notes: Packet kinds are decoded outside this block.
package lsc_pkg;
   typedef enum logic [1:0] {LSC_IDLE, LSC_ADV, LSC_CONN} lsc_link_type;
   typedef enum logic [2:0] {LSC_PH_GAP, LSC_PH_TX, LSC_PH_RX, LSC_PH_RSP} lsc_phase_type;
   // Received packet indications, each a one-cycle pulse.
   typedef struct packed {
      logic scan_req;
      logic conn_req;
      logic terminate;
      logic any_pkt;
   } lsc_rx_type;
   // Radio commands.
   typedef struct packed {
      logic tx_adv;
      logic tx_scan_rsp;
      logic tx_conn_rsp;
      logic tx_terminate;
      logic rx_on;
      logic [5:0] channel;
   } lsc_radio_type;
   // Host events, each a one-cycle pulse.
   typedef struct packed {
      logic adv_duration_expired_event;
      logic scan_response_sent_event;
      logic connection_established_event;
   } lsc_event_type;
endpackage : lsc_pkg

// [hw/lsc_ctrl.sv]
// Purpose: Link layer state controller for a slave-only device.
// Assumes: Radio reports packet kinds as one-cycle pulses; tx_done_i ends a transmission.
// Notes: Connection event timing itself is handled elsewhere.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defines.svh"
module lsc_ctrl
#(
   parameter bit HAS_ADV = 1'b1,
   parameter bit HAS_CONN = 1'b1,
   parameter int ADV_INTERVAL_CYC = `LSC_ADV_INTERVAL_CYC,
   parameter int LISTEN_CYC = `LSC_LISTEN_CYC,
   parameter int SUPERVISION_CYC = `LSC_SUPERVISION_CYC,
   parameter int ADV_DURATION_CYC = `LSC_ADV_DURATION_CYC
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic resetn_i,
   // Host control.
   input wire logic adv_enable_control_i,
   input wire logic local_terminate_i,
   // Radio.
   input wire lsc_pkg::lsc_rx_type rx_i,
   input wire logic tx_done_i,
   output lsc_pkg::lsc_radio_type radio_o,
   // Status.
   output logic [3:0] state_code_o,
   output lsc_pkg::lsc_event_type event_o
);
   lsc_pkg::lsc_link_type link, next_link;
   lsc_pkg::lsc_phase_type phase, next_phase;
   logic [5:0] chan, next_chan;
   logic [31:0] timer, next_timer;
   logic [31:0] dur, next_dur;
   logic [31:0] listen, next_listen;
   logic term_pend, next_term_pend;
   lsc_pkg::lsc_radio_type next_radio;
   lsc_pkg::lsc_event_type next_event;
   logic [3:0] next_code;

   function automatic logic [3:0] code_of(input lsc_pkg::lsc_link_type s);
      case (s)
         lsc_pkg::LSC_ADV: code_of = `LSC_CODE_ADV;
         lsc_pkg::LSC_CONN: code_of = `LSC_CODE_CONN;
         default: code_of = `LSC_CODE_IDLE;
      endcase
   endfunction : code_of

   always_comb
   begin
      next_link = link;
      next_phase = phase;
      next_chan = chan;
      next_timer = (timer != 32'h0) ? timer - 32'h1 : 32'h0;
      next_dur = dur;
      next_listen = (listen != 32'h0) ? listen - 32'h1 : 32'h0;
      next_term_pend = term_pend;
      next_radio = '0;
      next_radio.channel = chan;
      next_event = '0;
      case (link)
         lsc_pkg::LSC_IDLE:
         begin
            // Idle keeps the radio off and reports nothing; the channel reads zero as well.
            next_radio.channel = 6'h0; // [R3]
            next_phase = lsc_pkg::LSC_PH_GAP;
            if (adv_enable_control_i && HAS_ADV) // [R1] [R2] [R12]
            begin
               next_link = lsc_pkg::LSC_ADV;
               next_timer = 32'h0;
               next_dur = ADV_DURATION_CYC;
            end
         end
         lsc_pkg::LSC_ADV:
         begin
            if (dur != 32'h0)
               next_dur = dur - 32'h1;
            else
            begin
               next_event.adv_duration_expired_event = 1'b1; // [R13]
               next_dur = ADV_DURATION_CYC;
            end
            case (phase)
               lsc_pkg::LSC_PH_GAP:
               begin
                  // Enable is sampled only between events, so a channel is never cut short. [R15]
                  if (!adv_enable_control_i)
                     next_link = lsc_pkg::LSC_IDLE; // [R2]
                  else if (timer == 32'h0)
                  begin
                     next_chan = `LSC_CH_FIRST; // [R4]
                     next_phase = lsc_pkg::LSC_PH_TX;
                     next_timer = ADV_INTERVAL_CYC;
                  end
               end
               lsc_pkg::LSC_PH_TX:
               begin
                  next_radio.tx_adv = 1'b1;
                  if (tx_done_i)
                  begin
                     next_phase = lsc_pkg::LSC_PH_RX; // [R5]
                     next_listen = LISTEN_CYC;
                  end
               end
               lsc_pkg::LSC_PH_RX:
               begin
                  next_radio.rx_on = 1'b1; // [R5]
                  if (rx_i.conn_req && HAS_CONN)
                  begin
                     next_phase = lsc_pkg::LSC_PH_RSP; // [R7]
                  end
                  else if (rx_i.scan_req)
                     next_phase = lsc_pkg::LSC_PH_RSP; // [R6]
               end
               default:
               begin
                  next_phase = lsc_pkg::LSC_PH_GAP;
               end
            endcase
         end
         lsc_pkg::LSC_CONN:
         begin
            next_radio.rx_on = ~term_pend;
            if (rx_i.any_pkt)
               next_timer = SUPERVISION_CYC; // [R10]
            if (local_terminate_i)
               next_term_pend = 1'b1;
            if (term_pend)
            begin
               next_radio.tx_terminate = 1'b1; // [R9]
            end
            if ((term_pend && tx_done_i) || rx_i.terminate || timer == 32'h0) // [R8] [R9] [R10]
            begin
               next_term_pend = 1'b0;
               next_phase = lsc_pkg::LSC_PH_GAP;
               next_timer = 32'h0;
               // The exit follows the enable as it stands now, which is the last one written.
               if (adv_enable_control_i && HAS_ADV) // [R11]
                  next_link = lsc_pkg::LSC_ADV;
               else
                  next_link = lsc_pkg::LSC_IDLE;
               next_dur = ADV_DURATION_CYC;
            end
         end
         default:
         begin
            next_link = lsc_pkg::LSC_IDLE;
         end
      endcase
      // Response and channel stepping inside an advertising event.
      if (link == lsc_pkg::LSC_ADV && phase == lsc_pkg::LSC_PH_RX)
      begin
         if (rx_i.conn_req && HAS_CONN)
            next_radio.tx_conn_rsp = 1'b1;
         else if (rx_i.scan_req)
            next_radio.tx_scan_rsp = 1'b1; // [R6]
         // Every channel gets its own full window, so a late reply is still heard.
         else if (listen == 32'h0) // [R5]
         begin
            if (chan == `LSC_CH_LAST)
               next_phase = lsc_pkg::LSC_PH_GAP;
            else
            begin
               next_chan = chan + 6'h1; // [R4]
               next_phase = lsc_pkg::LSC_PH_TX;
            end
         end
      end
      if (link == lsc_pkg::LSC_ADV && phase == lsc_pkg::LSC_PH_RSP)
      begin
         if (radio_o.tx_conn_rsp)
         begin
            next_link = lsc_pkg::LSC_CONN; // [R7]
            next_event.connection_established_event = 1'b1; // [R13]
            next_timer = SUPERVISION_CYC;
         end
         else
         begin
            next_event.scan_response_sent_event = 1'b1; // [R13]
            if (chan == `LSC_CH_LAST)
               next_phase = lsc_pkg::LSC_PH_GAP;
            else
            begin
               next_chan = chan + 6'h1;
               next_phase = lsc_pkg::LSC_PH_TX;
            end
         end
      end
      next_code = code_of(next_link); // [R14]
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         link <= lsc_pkg::LSC_IDLE; // [R1]
         phase <= lsc_pkg::LSC_PH_GAP;
         chan <= `LSC_CH_FIRST;
         timer <= 32'h0;
         dur <= 32'h0;
         listen <= 32'h0;
         term_pend <= 1'b0;
         radio_o <= '0;
         event_o <= '0;
         state_code_o <= `LSC_CODE_IDLE;
      end
      else
      begin
         link <= next_link;
         phase <= next_phase;
         chan <= next_chan;
         timer <= next_timer;
         dur <= next_dur;
         listen <= next_listen;
         term_pend <= next_term_pend;
         radio_o <= next_radio;
         event_o <= next_event;
         state_code_o <= next_code;
      end
   end

   chk_idle_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_code_o == `LSC_CODE_IDLE && $past(state_code_o) == `LSC_CODE_IDLE)
      |-> (radio_o == '0 && event_o == '0)) // [R3]
      else $error("Idle state drives radio or events.");
   chk_no_conn_opt: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !HAS_CONN |-> state_code_o != `LSC_CODE_CONN) // [R12]
      else $error("Connection entered without connection option.");
   chk_conn_event: assert property (@(posedge clk_i) disable iff (!resetn_i)
      event_o.connection_established_event |-> state_code_o == `LSC_CODE_CONN) // [R13]
      else $error("Connection event without connection state.");
   chk_idle_to_adv: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_code_o == `LSC_CODE_IDLE && adv_enable_control_i && HAS_ADV)
      |=> state_code_o == `LSC_CODE_ADV) // [R2]
      else $error("Enable did not start advertising.");
   chk_term_exit: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_code_o == `LSC_CODE_CONN && rx_i.terminate)
      |=> state_code_o != `LSC_CODE_CONN) // [R8]
      else $error("Master terminate did not end connection.");
   chk_scan_reply: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (link == lsc_pkg::LSC_ADV && phase == lsc_pkg::LSC_PH_RX && rx_i.scan_req
       && !rx_i.conn_req) |=> radio_o.tx_scan_rsp ##1 event_o.scan_response_sent_event) // [R6]
      else $error("Scan request not answered.");
   chk_chan_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
      radio_o.tx_adv |-> (radio_o.channel >= `LSC_CH_FIRST
                          && radio_o.channel <= `LSC_CH_LAST)) // [R4]
      else $error("Advertising outside channels 37 to 39.");
   chk_exit_target: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (state_code_o == `LSC_CODE_CONN && rx_i.terminate && adv_enable_control_i && HAS_ADV)
      |=> state_code_o == `LSC_CODE_ADV) // [R11]
      else $error("Exit ignored the advertising enable.");
   chk_listen_holds: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R5]
      ($rose(radio_o.rx_on) && state_code_o == `LSC_CODE_ADV) |=> radio_o.rx_on)
      else $error("Listen window closed right after it opened.");
   chk_listen_follows: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R5]
      $fell(radio_o.tx_adv) |-> radio_o.rx_on)
      else $error("No listen window after an advertising packet.");
endmodule : lsc_ctrl
`default_nettype wire

// [test/lsc_master_model.sv]
// Purpose: Remote master and radio stand-in for the slave link state controller.
// Assumes: Replies and terminates are commanded by the bench.
// Notes: Request pulses are zero when idle, as pulse lines are never left floating.
`timescale 1ns/1ps
`default_nettype none
module lsc_master_model
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic resetn_i,
   // Bench commands: reply 1 is scan, 2 is connect.
   input wire logic [1:0] reply_i,
   input wire logic term_i,
   input wire logic alive_i,
   // Radio side of the controller.
   input wire lsc_pkg::lsc_radio_type radio_i,
   output lsc_pkg::lsc_rx_type rx_o,
   output logic tx_done_o
);
   logic [3:0] tx;
   logic [3:0] prev_tx;
   logic prev_rx;
   logic [2:0] tx_cnt;
   logic [6:0] alive_cnt;
   assign tx = {radio_i.tx_adv, radio_i.tx_scan_rsp, radio_i.tx_conn_rsp, radio_i.tx_terminate};
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rx_o <= '0;
         tx_done_o <= 1'b0;
         prev_tx <= '0;
         prev_rx <= 1'b0;
         tx_cnt <= '0;
         alive_cnt <= '0;
      end
      else
      begin
         prev_tx <= tx;
         prev_rx <= radio_i.rx_on;
         alive_cnt <= alive_cnt + 7'h01;
         // A few cycles of air time, so the controller cannot rely on an instant finish.
         tx_cnt <= (tx != prev_tx && tx != 4'h0) ? 3'h4 : (tx_cnt != 3'h0 ? tx_cnt - 3'h1 : 3'h0);
         tx_done_o <= (tx_cnt == 3'h1);
         // Requests only ever follow the opening of a listen window, in advertising or in a connection.
         rx_o.scan_req <= radio_i.rx_on && !prev_rx && reply_i == 2'h1;
         rx_o.conn_req <= radio_i.rx_on && !prev_rx && reply_i == 2'h2;
         rx_o.terminate <= term_i;
         rx_o.any_pkt <= (radio_i.rx_on && !prev_rx && reply_i != 2'h0) || term_i
            || (alive_i && alive_cnt == 7'h00);
      end
   end
endmodule : lsc_master_model
`default_nettype wire

// [test/lsc_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the slave link state controller.
// Assumes: Shortened timing parameters; one master model.
// Notes: Build options other than the full one are not exercised here.
`timescale 1ns/1ps
`default_nettype none
module lsc_ctrl_tb_top;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic adv_en = 1'b0;
   logic lterm = 1'b0;
   logic term = 1'b0;
   logic alive = 1'b0;
   logic [1:0] reply = 2'h0;
   lsc_pkg::lsc_rx_type rx;
   logic tx_done;
   lsc_pkg::lsc_radio_type radio;
   logic [3:0] code;
   lsc_pkg::lsc_event_type ev;
   logic prev_adv = 1'b0;
   logic prev_tt = 1'b0;
   logic [3:0] prev_code = 4'h0;
   int failures = 0;
   int checked = 0;
   int n_scan = 0;
   int n_conn = 0;
   int n_dur = 0;
   int n_tt = 0;
   int n_busy = 0;
   logic [5:0] chans[$];
   always #4 clk_i = ~clk_i;
   lsc_ctrl #(.ADV_INTERVAL_CYC(200), .LISTEN_CYC(20), .SUPERVISION_CYC(500),
      .ADV_DURATION_CYC(2000)) u_lsc_ctrl (.clk_i(clk_i), .resetn_i(resetn_i),
      .adv_enable_control_i(adv_en), .local_terminate_i(lterm), .rx_i(rx),
      .tx_done_i(tx_done), .radio_o(radio), .state_code_o(code), .event_o(ev));
   lsc_master_model u_lsc_master_model (.clk_i(clk_i), .resetn_i(resetn_i), .reply_i(reply),
      .term_i(term), .alive_i(alive), .radio_i(radio), .rx_o(rx), .tx_done_o(tx_done));
   always @(posedge clk_i)
   begin
      prev_adv <= radio.tx_adv;
      prev_tt <= radio.tx_terminate;
      prev_code <= code;
      if (radio.tx_adv && !prev_adv) chans.push_back(radio.channel);
      if (radio.tx_terminate && !prev_tt) n_tt++;
      if (ev.scan_response_sent_event) n_scan++;
      if (ev.connection_established_event) n_conn++;
      if (ev.adv_duration_expired_event) n_dur++;
      // Settled Idle only, so the last cycle of a departing state is not held against it.
      if (resetn_i && code == 4'h0 && prev_code == 4'h0 && (radio != '0 || ev != '0)) n_busy++;
   end
   task automatic finish_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cycles
   task automatic wait_code(input logic [3:0] c, input int lim);
      for (int i = 0; i < lim && code !== c; i++) cycles(1);
      check("state_code", 32'(code), 32'(c));
      if (code !== c) finish_test();
   endtask : wait_code
   task automatic t_reset();
      cycles(2);
      check("reset_code", 32'(code), 32'h0);
      cycles(18);
      resetn_i <= 1'b1;
      cycles(50);
      check("idle_code", 32'(code), 32'h0);
   endtask : t_reset
   task automatic t_adv();
      adv_en <= 1'b1;
      wait_code(4'h1, 4);
      cycles(2100);
      check("chan_first", 32'(chans[0]), 32'h25);
      check("chan_second", 32'(chans[1]), 32'h26);
      check("chan_third", 32'(chans[2]), 32'h27);
      check("per_interval", 32'(chans.size() >= 27 && chans.size() <= 33), 32'h1);
      check("duration", 32'(n_dur >= 1), 32'h1);
      check("idle_quiet", 32'(n_busy), 32'h0);
   endtask : t_adv
   task automatic t_scan();
      reply <= 2'h1;
      for (int i = 0; i < 600 && n_scan == 0; i++) cycles(1);
      reply <= 2'h0;
      check("scan_event", 32'(n_scan >= 1), 32'h1);
      check("scan_code", 32'(code), 32'h1);
      if (n_scan == 0) finish_test();
   endtask : t_scan
   task automatic t_conn(input logic keep);
      reply <= 2'h2;
      alive <= keep;
      wait_code(4'h8, 600);
      reply <= 2'h0;
   endtask : t_conn
   task automatic t_mterm();
      t_conn(1'b1);
      check("conn_event", 32'(ev.connection_established_event), 32'h1);
      cycles(700);
      check("alive_code", 32'(code), 32'h8);
      term <= 1'b1;
      cycles(1);
      term <= 1'b0;
      wait_code(4'h1, 4);
   endtask : t_mterm
   task automatic t_lterm();
      t_conn(1'b1);
      adv_en <= 1'b0;
      lterm <= 1'b1;
      cycles(1);
      lterm <= 1'b0;
      wait_code(4'h0, 300);
      check("term_sent", 32'(n_tt), 32'h1);
      alive <= 1'b0;
   endtask : t_lterm
   task automatic t_timeout();
      int n;
      adv_en <= 1'b1;
      wait_code(4'h1, 4);
      t_conn(1'b0);
      n = 0;
      for (int i = 0; i < 1000 && code === 4'h8; i++)
      begin
         n++;
         cycles(1);
      end
      check("sup_long", 32'(n >= 490 && n <= 510), 32'h1);
      check("sup_code", 32'(code), 32'h1);
      if (code !== 4'h1) finish_test();
   endtask : t_timeout
   task automatic t_disable();
      for (int i = 0; i < 400 && radio.tx_adv !== 1'b1; i++) cycles(1);
      check("adv_seen", 32'(radio.tx_adv), 32'h1);
      if (radio.tx_adv !== 1'b1) finish_test();
      adv_en <= 1'b0;
      cycles(3);
      check("mid_event", 32'(code), 32'h1);
      wait_code(4'h0, 400);
   endtask : t_disable
   initial
   begin
      #800000;
      failures++;
      finish_test();
   end
   initial
   begin
      t_reset();
      t_adv();
      t_scan();
      t_mterm();
      t_lterm();
      t_timeout();
      t_disable();
      cycles(50);
      check("idle_end", 32'(n_busy), 32'h0);
      check("conn_count", 32'(n_conn), 32'h3);
      finish_test();
   end
endmodule : lsc_ctrl_tb_top
`default_nettype wire
